// file: core/gpcsr_regs.v
`timescale 1ns/1ns
`default_nettype none
`include "gpcsr_defs.vh"
module gpcsr_regs #(
  parameter IDLE_WIDTH = 8
) (
  input wire I_CLK_SYS, // core clock, 125 MHz
  input wire I_ARST_N, // async reset, active low
  // management register port
  input wire I_REG_WR, // write strobe, one cycle
  input wire I_REG_RD, // read strobe, one cycle
  input wire [4:0] I_REG_ADDR, // register address
  input wire [15:0] I_REG_WDATA, // write data
  output reg [15:0] O_REG_RDATA, // read data, one cycle after strobe
  output reg O_REG_RVALID, // read data valid pulse
  // gigabit status inputs from the media side
  input wire I_MS_FAULT, // master/slave fault detected
  input wire I_MS_RESOLVED_MASTER, // role resolved to master
  input wire I_LOCAL_RX_OK, // local receiver normal
  input wire I_REMOTE_RX_OK, // remote receiver ok
  input wire I_LINK_PARTNER_FDX, // partner gigabit fdx able
  input wire I_LINK_PARTNER_HDX, // partner gigabit hdx able
  input wire I_IDLE_ERR, // one idle error
  // fast ethernet status inputs
  input wire I_FE_LOCKED, // descrambler locked
  input wire I_FE_LINK, // link active
  input wire I_FE_LOCK_ERR, // lock error event
  input wire I_FE_DISCONNECT, // disconnect event
  input wire I_FE_RX_ERR, // receive error event
  input wire I_FE_TX_ERR, // transmit error event
  input wire I_FE_STREAM_START_DELIMITER_ERR, // start delimiter error
  input wire I_FE_STREAM_END_DELIMITER_ERR, // end delimiter error
  // controls to the negotiation and test logic
  output reg [2:0] O_TEST_MODE, // decoded test mode, 0 normal
  output reg O_NEG_MANUAL, // use software role
  output reg O_NEG_MASTER, // role to negotiate when manual
  output wire O_PORT_MULTI, // advertise multi-port
  output wire O_ADV_FDX, // advertise gigabit fdx
  output wire O_ADV_HDX, // advertise gigabit hdx
  // clause 45 indirect access port
  output reg O_C45_WR, // write strobe
  output reg O_C45_RD, // read strobe
  output wire [4:0] O_C45_CLAUSE45_DEVICE_SELECT, // target device
  output wire [15:0] O_C45_ADDR, // target register address
  output wire [15:0] O_C45_WDATA, // write data
  input wire [15:0] I_C45_RDATA // register contents, combinational
);
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  reg [15:0] gig_ctrl;
  reg [15:0] ind_ctrl;
  reg [15:0] ind_addr;
  reg [15:0] ind_wdata;
  wire [1:0] func;
  wire data_mode;
  wire wr_ctrl;
  wire wr_ind_ctrl;
  wire wr_window;
  wire rd_window;
  wire rd_stat;
  wire rd_fe;
  wire [5:0] fe_flags;
  wire [IDLE_WIDTH-1:0] idle_count;
  wire ms_fault_flag;
  reg [15:0] next_rdata;

  // ----------------------------------------
  // access decode
  // ----------------------------------------
  // one shared address decode for reads and writes
  // a function, so the read and write sides can never disagree on a hit
  function hit;
    input [4:0] addr;
    input [4:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign wr_ctrl = I_REG_WR && hit(I_REG_ADDR, `GPCSR_ADDR_GIG_CTRL);
  assign wr_ind_ctrl = I_REG_WR && hit(I_REG_ADDR, `GPCSR_ADDR_IND_CTRL);
  assign wr_window = I_REG_WR && hit(I_REG_ADDR, `GPCSR_ADDR_IND_DATA);
  assign rd_window = I_REG_RD && hit(I_REG_ADDR, `GPCSR_ADDR_IND_DATA);
  assign rd_stat = I_REG_RD && hit(I_REG_ADDR, `GPCSR_ADDR_GIG_STAT);
  assign rd_fe = I_REG_RD && hit(I_REG_ADDR, `GPCSR_ADDR_FE_EXT);
  assign func = ind_ctrl[`GPCSR_IND_FUNC_HI:`GPCSR_IND_FUNC_LO];
  assign data_mode = (func != `GPCSR_FUNC_ADDRESS);

  // control register, all bits writable including reserved low byte
  always @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      gig_ctrl <= `GPCSR_CTRL_RESET;
    else if (wr_ctrl)
      gig_ctrl <= I_REG_WDATA;
  end

  assign O_PORT_MULTI = gig_ctrl[`GPCSR_CTRL_PORT_TYPE];
  assign O_ADV_FDX = gig_ctrl[`GPCSR_CTRL_ADV_FDX];
  assign O_ADV_HDX = gig_ctrl[`GPCSR_CTRL_ADV_HDX];

  // ----------------------------------------
  // test mode and role decode
  // ----------------------------------------
  // the media sense switch lives outside this block; software clears it
  // before selecting any nonzero test mode, nothing here enforces that
  // reserved codes fall back to normal so the transmitter never sees them
  always @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_TEST_MODE <= `GPCSR_TEST_NORMAL;
      O_NEG_MANUAL <= 1'b0;
      O_NEG_MASTER <= 1'b0;
    end
    else
    begin
      case (gig_ctrl[`GPCSR_CTRL_TEST_HI:`GPCSR_CTRL_TEST_LO])
        `GPCSR_TEST_WAVEFORM: O_TEST_MODE <= `GPCSR_TEST_WAVEFORM;
        `GPCSR_TEST_JITTER_MASTER: O_TEST_MODE <= `GPCSR_TEST_JITTER_MASTER;
        `GPCSR_TEST_JITTER_SLAVE: O_TEST_MODE <= `GPCSR_TEST_JITTER_SLAVE;
        `GPCSR_TEST_DISTORTION: O_TEST_MODE <= `GPCSR_TEST_DISTORTION;
        default: O_TEST_MODE <= `GPCSR_TEST_NORMAL;
      endcase
      O_NEG_MANUAL <= gig_ctrl[`GPCSR_CTRL_MS_MANUAL];
      // value bit is masked unless manual mode is on
      O_NEG_MASTER <= gig_ctrl[`GPCSR_CTRL_MS_MANUAL] & gig_ctrl[`GPCSR_CTRL_MS_VALUE];
    end
  end

  // ----------------------------------------
  // indirect access window
  // ----------------------------------------
  // access control: reserved middle bits are kept and read back as written
  always @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      ind_ctrl <= 16'h0000;
    else if (wr_ind_ctrl)
      ind_ctrl <= I_REG_WDATA;
  end

  // target selection and write data follow their registers directly
  assign O_C45_CLAUSE45_DEVICE_SELECT = ind_ctrl[`GPCSR_IND_DEV_HI:`GPCSR_IND_DEV_LO];
  assign O_C45_WDATA = ind_wdata;

  // address load in address mode, post-increment per function code
  always @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      ind_addr <= 16'h0000;
    else if (!data_mode && wr_window)
      ind_addr <= I_REG_WDATA;
    else if (data_mode)
    begin
      case (func)
        `GPCSR_FUNC_DATA_INC_RW:
          if (wr_window || rd_window)
            ind_addr <= ind_addr + 16'h0001;
        `GPCSR_FUNC_DATA_INC_WR:
          if (wr_window)
            ind_addr <= ind_addr + 16'h0001;
        default:
          ind_addr <= ind_addr;
      endcase
    end
  end

  // strobes to the target are registered, one cycle behind the access;
  // the increment lands on the edge that takes a window write, so the
  // write strobe carries a copy of the address from before that edge
  reg [15:0] c45_addr_hold;
  always @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_C45_WR <= 1'b0;
      O_C45_RD <= 1'b0;
      ind_wdata <= 16'h0000;
      c45_addr_hold <= 16'h0000;
    end
    else
    begin
      O_C45_WR <= wr_window && data_mode;
      // read data was taken at the access edge; this only tells targets
      // with read side effects that a read was served
      O_C45_RD <= rd_window && data_mode;
      c45_addr_hold <= ind_addr;
      if (wr_window && data_mode)
        ind_wdata <= I_REG_WDATA;
    end
  end

  // limitation: a window read right behind a data write sees the write's
  // address on the target port, so software leaves one idle cycle there
  assign O_C45_ADDR = O_C45_WR ? c45_addr_hold : ind_addr;

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // fault latches high until read, held while the fault stays present
  gpcsr_sticky #(
    .WIDTH(1)
  ) u_ms_fault (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .i_event(I_MS_FAULT),
    .i_clear(rd_stat),
    .o_flag(ms_fault_flag)
  );

  // saturating idle error count, so a burst of errors never wraps to zero
  gpcsr_idle_count #(
    .WIDTH(IDLE_WIDTH)
  ) u_idle (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .i_inc(I_IDLE_ERR),
    .i_clear(rd_stat),
    .o_count(idle_count)
  );

  // self-clearing fast ethernet event flags, order bit 14 down to 8
  gpcsr_sticky #(
    .WIDTH(6)
  ) u_fe_flags (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .i_event({I_FE_LOCK_ERR, I_FE_DISCONNECT, I_FE_RX_ERR, I_FE_TX_ERR,
              I_FE_STREAM_START_DELIMITER_ERR, I_FE_STREAM_END_DELIMITER_ERR}),
    .i_clear(rd_fe),
    .o_flag(fe_flags)
  );

  // resolved role resets to master until the media side says otherwise
  // registered so a status read never catches the role mid-change
  reg ms_resolved;
  always @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      ms_resolved <= 1'b1;
    else
      ms_resolved <= I_MS_RESOLVED_MASTER;
  end

  // ----------------------------------------
  // status word assembly
  // ----------------------------------------
  // whole words built apart from the mux; every bit starts at zero, so the
  // reserved positions read zero without a case of their own
  reg [15:0] gig_stat_word;
  reg [15:0] fe_stat_word;

  always @*
  begin
    gig_stat_word = 16'h0000;
    gig_stat_word[`GPCSR_STAT_MS_FAULT] = ms_fault_flag;
    gig_stat_word[`GPCSR_STAT_MS_RESOLVED] = ms_resolved;
    gig_stat_word[`GPCSR_STAT_LOCAL_RX] = I_LOCAL_RX_OK;
    gig_stat_word[`GPCSR_STAT_REMOTE_RX] = I_REMOTE_RX_OK;
    gig_stat_word[`GPCSR_STAT_LINK_PARTNER_FDX] = I_LINK_PARTNER_FDX;
    gig_stat_word[`GPCSR_STAT_LINK_PARTNER_HDX] = I_LINK_PARTNER_HDX;
    gig_stat_word[IDLE_WIDTH-1:0] = idle_count;
  end

  // flag order in fe_flags is bit 14 down to bit 8, skipping link at 12
  always @*
  begin
    fe_stat_word = 16'h0000;
    fe_stat_word[`GPCSR_FE_LOCKED] = I_FE_LOCKED;
    fe_stat_word[`GPCSR_FE_LINK] = I_FE_LINK;
    fe_stat_word[`GPCSR_FE_LOCK_ERR] = fe_flags[5];
    fe_stat_word[`GPCSR_FE_DISCONNECT] = fe_flags[4];
    fe_stat_word[`GPCSR_FE_RX_ERR] = fe_flags[3];
    fe_stat_word[`GPCSR_FE_TX_ERR] = fe_flags[2];
    fe_stat_word[`GPCSR_FE_STREAM_START_DELIMITER_ERR] = fe_flags[1];
    fe_stat_word[`GPCSR_FE_STREAM_END_DELIMITER_ERR] = fe_flags[0];
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @*
  begin
    next_rdata = 16'h0000;
    case (I_REG_ADDR)
      `GPCSR_ADDR_GIG_CTRL: next_rdata = gig_ctrl;
      `GPCSR_ADDR_GIG_STAT: next_rdata = gig_stat_word;
      `GPCSR_ADDR_IND_CTRL: next_rdata = ind_ctrl;
      `GPCSR_ADDR_IND_DATA: next_rdata = data_mode ? I_C45_RDATA : ind_addr;
      `GPCSR_ADDR_GIG_EXT1: next_rdata = `GPCSR_EXT1_VALUE;
      `GPCSR_ADDR_FE_EXT: next_rdata = fe_stat_word;
      default: next_rdata = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // read data register
  // ----------------------------------------
  // data changes only on a read, so it stands until the next one
  always @(posedge I_CLK_SYS or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      O_REG_RDATA <= 16'h0000;
      O_REG_RVALID <= 1'b0;
    end
    else
    begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD)
        O_REG_RDATA <= next_rdata;
    end
  end
endmodule // gpcsr_regs
`default_nettype wire

// file: core/gpcsr_defs.vh
`ifndef GPCSR_DEFS_VH
`define GPCSR_DEFS_VH
// register addresses on the management register port
`define GPCSR_ADDR_GIG_CTRL 5'h09
`define GPCSR_ADDR_GIG_STAT 5'h0A
`define GPCSR_ADDR_IND_CTRL 5'h0D
`define GPCSR_ADDR_IND_DATA 5'h0E
`define GPCSR_ADDR_GIG_EXT1 5'h0F
`define GPCSR_ADDR_FE_EXT 5'h10
// gigabit control fields
`define GPCSR_CTRL_TEST_HI 15
`define GPCSR_CTRL_TEST_LO 13
`define GPCSR_CTRL_MS_MANUAL 12
`define GPCSR_CTRL_MS_VALUE 11
`define GPCSR_CTRL_PORT_TYPE 10
`define GPCSR_CTRL_ADV_FDX 9
`define GPCSR_CTRL_ADV_HDX 8
`define GPCSR_CTRL_RESET 16'h0700
// test mode codes
`define GPCSR_TEST_NORMAL 3'h0
`define GPCSR_TEST_WAVEFORM 3'h1
`define GPCSR_TEST_JITTER_MASTER 3'h2
`define GPCSR_TEST_JITTER_SLAVE 3'h3
`define GPCSR_TEST_DISTORTION 3'h4
// gigabit status fields
`define GPCSR_STAT_MS_FAULT 15
`define GPCSR_STAT_MS_RESOLVED 14
`define GPCSR_STAT_LOCAL_RX 13
`define GPCSR_STAT_REMOTE_RX 12
`define GPCSR_STAT_LINK_PARTNER_FDX 11
`define GPCSR_STAT_LINK_PARTNER_HDX 10
// indirect access control fields
`define GPCSR_IND_FUNC_HI 15
`define GPCSR_IND_FUNC_LO 14
`define GPCSR_IND_DEV_HI 4
`define GPCSR_IND_DEV_LO 0
`define GPCSR_FUNC_ADDRESS 2'h0
`define GPCSR_FUNC_DATA_NOINC 2'h1
`define GPCSR_FUNC_DATA_INC_RW 2'h2
`define GPCSR_FUNC_DATA_INC_WR 2'h3
// fixed extended status value: gigabit fdx and hdx supported
`define GPCSR_EXT1_VALUE 16'h3000
// fast ethernet status fields
`define GPCSR_FE_LOCKED 15
`define GPCSR_FE_LOCK_ERR 14
`define GPCSR_FE_DISCONNECT 13
`define GPCSR_FE_LINK 12
`define GPCSR_FE_RX_ERR 11
`define GPCSR_FE_TX_ERR 10
`define GPCSR_FE_STREAM_START_DELIMITER_ERR 9
`define GPCSR_FE_STREAM_END_DELIMITER_ERR 8
`endif

// file: core/gpcsr_sticky.v
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// latched-high event flags, cleared by read
// ----------------------------------------
module gpcsr_sticky #(
  parameter WIDTH = 6
) (
  input wire i_clk, // core clock
  input wire i_arst_n, // async reset, active low
  input wire [WIDTH-1:0] i_event, // event strobes or levels
  input wire i_clear, // register read this cycle
  output reg [WIDTH-1:0] o_flag // latched flags
);
  // set wins over the read clear so an event in the read cycle is kept
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_flag
      always @(posedge i_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
          o_flag[g] <= 1'b0;
        else if (i_event[g])
          o_flag[g] <= 1'b1;
        else if (i_clear)
          o_flag[g] <= 1'b0;
      end
    end
  endgenerate
endmodule // gpcsr_sticky
`default_nettype wire

// file: core/gpcsr_idle_count.v
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// saturating idle error counter, cleared by read
// ----------------------------------------
module gpcsr_idle_count #(
  parameter WIDTH = 8
) (
  input wire i_clk, // core clock
  input wire i_arst_n, // async reset, active low
  input wire i_inc, // one idle error this cycle
  input wire i_clear, // register read this cycle
  output reg [WIDTH-1:0] o_count // current count
);
  // an error seen in the read cycle restarts the count at one, not lost
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_count <= {WIDTH{1'b0}};
    else if (i_clear)
      o_count <= {{(WIDTH-1){1'b0}}, i_inc};
    else if (i_inc && !(&o_count))
      o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1}; // saturates at all ones
  end
endmodule // gpcsr_idle_count
`default_nettype wire

// file: tb/gpcsr_regs_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// register bank port checker
// ----------------------------------------
module gpcsr_regs_chk (
  input wire logic I_CLK_SYS, // core clock
  input wire logic I_ARST_N, // async reset, active low
  input wire logic I_REG_WR, // write strobe
  input wire logic I_REG_RD, // read strobe
  input wire logic [4:0] I_REG_ADDR, // register address
  input wire logic [15:0] I_REG_WDATA, // write data
  input wire logic [15:0] O_REG_RDATA, // read data
  input wire logic O_REG_RVALID, // read data valid
  input wire logic I_MS_FAULT, // role fault level
  input wire logic [2:0] O_TEST_MODE, // decoded test mode
  input wire logic O_NEG_MANUAL, // software role in use
  input wire logic O_NEG_MASTER, // software role value
  input wire logic O_PORT_MULTI, // multi-port advert
  input wire logic O_ADV_FDX, // fdx advert
  input wire logic O_ADV_HDX, // hdx advert
  input wire logic O_C45_WR, // indirect write strobe
  input wire logic [4:0] O_C45_CLAUSE45_DEVICE_SELECT, // target device
  input wire logic [15:0] O_C45_WDATA // indirect write data
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_ARST_N);
  // access decodes, shared by the properties
  wire wr_ctrl = I_REG_WR && I_REG_ADDR == 5'h09;
  wire rd_stat = I_REG_RD && I_REG_ADDR == 5'h0A;
  read_valid_a: assert property (O_REG_RVALID == $past(I_REG_RD))
    else $error("read valid not one cycle after strobe");
  test_decode_a: assert property (wr_ctrl |-> ##2 O_TEST_MODE ==
    (($past(I_REG_WDATA[15:13], 2) > 3'h4) ? 3'h0 : $past(I_REG_WDATA[15:13], 2)))
    else $error("test mode decode wrong");
  manual_role_a: assert property (wr_ctrl |-> ##2 O_NEG_MANUAL == $past(I_REG_WDATA[12], 2)
    && O_NEG_MASTER == ($past(I_REG_WDATA[12], 2) & $past(I_REG_WDATA[11], 2)))
    else $error("manual role wrong");
  advert_bits_a: assert property (wr_ctrl |=> {O_PORT_MULTI, O_ADV_FDX, O_ADV_HDX} == $past(I_REG_WDATA[10:8]))
    else $error("advertised bits wrong");
  ext_status_a: assert property (I_REG_RD && I_REG_ADDR == 5'h0F |=> O_REG_RDATA == 16'h3000)
    else $error("extended status wrong");
  fault_latch_a: assert property ((I_MS_FAULT ##1 rd_stat) or (I_MS_FAULT ##1 !rd_stat ##1 rd_stat)
    |=> O_REG_RDATA[15])
    else $error("fault bit not latched");
  stat_resv_a: assert property (rd_stat |=> O_REG_RDATA[9:8] == 2'b00)
    else $error("status reserved bits set");
  fe_low_byte_a: assert property (I_REG_RD && I_REG_ADDR == 5'h10 |=> O_REG_RDATA[7:0] == 8'h00)
    else $error("fast status low byte set");
  dev_select_a: assert property (I_REG_WR && I_REG_ADDR == 5'h0D |=>
    O_C45_CLAUSE45_DEVICE_SELECT == $past(I_REG_WDATA[4:0]))
    else $error("device select wrong");
  c45_write_a: assert property (O_C45_WR |-> $past(I_REG_WR && I_REG_ADDR == 5'h0E)
    && O_C45_WDATA == $past(I_REG_WDATA))
    else $error("indirect write without window write");
endmodule // gpcsr_regs_chk
bind gpcsr_regs gpcsr_regs_chk u_chk (.*);
`default_nettype wire

// file: tb/gpcsr_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// register bank testbench
// ----------------------------------------
module gpcsr_regs_tb;
  logic I_CLK_SYS = 1'b0, I_ARST_N = 1'b0, I_REG_WR = 1'b0, I_REG_RD = 1'b0, I_IDLE_ERR = 1'b0;
  logic I_FE_LOCKED = 1'b0, I_FE_LINK = 1'b0;
  logic [4:0] I_REG_ADDR = 5'h00;
  logic [15:0] I_REG_WDATA = 16'h0000;
  logic [5:0] gig_lv = 6'h10; // fault, resolved, local, remote, partner fdx, hdx
  logic [5:0] fe_ev = 6'h00; // lock, disconnect, rx, tx, start, end
  wire logic I_MS_FAULT, I_MS_RESOLVED_MASTER, I_LOCAL_RX_OK, I_REMOTE_RX_OK, I_LINK_PARTNER_FDX;
  wire logic I_LINK_PARTNER_HDX, I_FE_LOCK_ERR, I_FE_DISCONNECT, I_FE_RX_ERR, I_FE_TX_ERR;
  wire logic I_FE_STREAM_START_DELIMITER_ERR, I_FE_STREAM_END_DELIMITER_ERR;
  wire logic O_REG_RVALID, O_NEG_MANUAL, O_NEG_MASTER, O_PORT_MULTI, O_ADV_FDX, O_ADV_HDX, O_C45_WR, O_C45_RD;
  wire logic [2:0] O_TEST_MODE;
  wire logic [4:0] O_C45_CLAUSE45_DEVICE_SELECT;
  wire logic [15:0] O_REG_RDATA, O_C45_ADDR, O_C45_WDATA, I_C45_RDATA;
  int fail_count = 0;
  int samples_checked = 0;
  assign {I_MS_FAULT, I_MS_RESOLVED_MASTER, I_LOCAL_RX_OK, I_REMOTE_RX_OK, I_LINK_PARTNER_FDX,
    I_LINK_PARTNER_HDX} = gig_lv;
  assign {I_FE_LOCK_ERR, I_FE_DISCONNECT, I_FE_RX_ERR, I_FE_TX_ERR, I_FE_STREAM_START_DELIMITER_ERR,
    I_FE_STREAM_END_DELIMITER_ERR} = fe_ev;
  // far register content: inverted address, so any address slip shows
  assign I_C45_RDATA = ~O_C45_ADDR;
  gpcsr_regs u_gpcsr_regs (.*);
  // 125 MHz core clock
  initial
  begin
    forever #4 I_CLK_SYS = ~I_CLK_SYS;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge I_CLK_SYS);
    I_REG_WR <= 1'b1;
    I_REG_ADDR <= a;
    I_REG_WDATA <= d;
    @(posedge I_CLK_SYS);
    I_REG_WR <= 1'b0;
    #1;
  endtask
  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge I_CLK_SYS);
    I_REG_RD <= 1'b1;
    I_REG_ADDR <= a;
    @(posedge I_CLK_SYS);
    I_REG_RD <= 1'b0;
    #1;
    chk({15'h0, O_REG_RVALID}, 16'h0001);
    chk(O_REG_RDATA, e);
  endtask
  task tick;
    @(posedge I_CLK_SYS);
    #1;
  endtask
  task final_report;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // reset values, read-only refusal, unmapped place
  task t_reset;
    rd(5'h09, 16'h0700);
    rd(5'h0A, 16'h4000);
    wr(5'h0F, 16'hFFFF);
    rd(5'h0F, 16'h3000);
    rd(5'h10, 16'h0000);
    rd(5'h1F, 16'h0000);
    $display("reset test done");
  endtask
  // every test code, reserved ones must fall back to normal
  // media sense sits outside this block and counts as off here
  task t_modes;
    for (int v = 0; v < 8; v++)
    begin
      wr(5'h09, {v[2:0], 13'h0700});
      tick;
      chk({13'h0, O_TEST_MODE}, (v > 4) ? 16'h0000 : {13'h0, v[2:0]});
    end
    $display("test mode test done");
  endtask
  // manual role and advertised abilities
  task t_role;
    wr(5'h09, 16'h1800);
    tick;
    chk({14'h0, O_NEG_MANUAL, O_NEG_MASTER}, 16'h0003);
    wr(5'h09, 16'h0800);
    tick;
    chk({14'h0, O_NEG_MANUAL, O_NEG_MASTER}, 16'h0000);
    wr(5'h09, 16'h1000);
    tick;
    chk({14'h0, O_NEG_MANUAL, O_NEG_MASTER}, 16'h0002);
    chk({13'h0, O_PORT_MULTI, O_ADV_FDX, O_ADV_HDX}, 16'h0000);
    rd(5'h09, 16'h1000);
    wr(5'h09, 16'h0700);
    chk({13'h0, O_PORT_MULTI, O_ADV_FDX, O_ADV_HDX}, 16'h0007);
    $display("role test done");
  endtask
  // fault latch and idle count, both cleared by the read
  task t_status;
    @(posedge I_CLK_SYS);
    gig_lv <= 6'b101111;
    I_IDLE_ERR <= 1'b1;
    repeat (3) @(posedge I_CLK_SYS);
    gig_lv <= 6'b001111;
    I_IDLE_ERR <= 1'b0;
    rd(5'h0A, 16'hBC03);
    rd(5'h0A, 16'h3C00);
    gig_lv <= 6'h10;
    $display("status test done");
  endtask
  // one cycle of every fast ethernet event
  task t_fast;
    @(posedge I_CLK_SYS);
    fe_ev <= 6'h3F;
    I_FE_LOCKED <= 1'b1;
    I_FE_LINK <= 1'b1;
    @(posedge I_CLK_SYS);
    fe_ev <= 6'h00;
    rd(5'h10, 16'hFF00);
    rd(5'h10, 16'h9000);
    $display("fast status test done");
  endtask
  // indirect window in each function code
  task t_ind;
    wr(5'h0D, 16'h0007);
    chk({11'h0, O_C45_CLAUSE45_DEVICE_SELECT}, 16'h0007);
    wr(5'h0E, 16'h0020);
    chk(O_C45_ADDR, 16'h0020);
    rd(5'h0E, 16'h0020);
    chk({15'h0, O_C45_RD}, 16'h0000);
    wr(5'h0D, 16'h4007);
    wr(5'h0E, 16'h1234);
    chk({15'h0, O_C45_WR}, 16'h0001);
    chk(O_C45_WDATA, 16'h1234);
    chk(O_C45_ADDR, 16'h0020);
    rd(5'h0E, 16'hFFDF);
    chk({15'h0, O_C45_RD}, 16'h0001);
    tick;
    chk(O_C45_ADDR, 16'h0020);
    wr(5'h0D, 16'h8007);
    rd(5'h0E, 16'hFFDF);
    tick;
    chk(O_C45_ADDR, 16'h0021);
    wr(5'h0E, 16'h5555);
    chk(O_C45_ADDR, 16'h0021);
    tick;
    chk(O_C45_ADDR, 16'h0022);
    wr(5'h0D, 16'hC007);
    rd(5'h0E, 16'hFFDD);
    tick;
    chk(O_C45_ADDR, 16'h0022);
    wr(5'h0E, 16'h5678);
    chk(O_C45_ADDR, 16'h0022);
    tick;
    chk(O_C45_ADDR, 16'h0023);
    $display("indirect test done");
  endtask
  initial
  begin
    repeat (16) @(posedge I_CLK_SYS);
    I_ARST_N <= 1'b1;
    t_reset;
    t_modes;
    t_role;
    t_status;
    t_fast;
    t_ind;
    final_report;
  end
  // the whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge I_CLK_SYS);
    fail_count++;
    final_report;
  end
endmodule // gpcsr_regs_tb
`default_nettype wire
